// ==== verilog/sne_engine.sv ====
/*
  Instruction engine of a serial EEPROM slave: array, identification
  page, lock and serial number access with a self-timed write cycle.
  Assumes a mode 0 or 3 serial host; sck_in runs only inside frames.
*/
// What this block does
// - array read is refused while a write cycle runs
// - select rise after a write starts a timed cycle, then busy clears
// - each write cycle erases first, then programs
// - further data bytes up to page end go into one cycle
// - only low address bits step; overflow wraps within the page
// - write refused without latch, while busy, off boundary, or protected
// - array reads correct one bad bit per aligned four-byte group
// - partly written group gets its other bytes rewritten unchanged
// - ident read: A10 zero, low five bits start, auto-increment
// - ident write: A10 zero, low five bits give the byte offset
// - lock status read: A10 one, lsb shows page lock
// - lock status byte repeats while select stays low
// - lock needs a prior write enable
// - lock only when select rises right after the eighth data bit
// - lock discarded while busy or with both protect bits set
// - serial read: A9 one, low four bits pick byte, auto-increment
// - after power-up: deselected, latch and busy zero
// - delivered contents read all ones, lock and protection zero
// - array read steps the address and wraps to zero
// - busy reads one during a write cycle, else zero
// - latch clears when an array or ident write completes
`timescale 1ns/100ps
`default_nettype none
`include "sne_map.svh"
module sne_engine #(
  parameter int MEM_BYTES = `SNE_MEM_BYTES,
  parameter int T_WRITE = `SNE_SELF_TIMED_WRITE_TIME_NS / `SNE_CLK_NS,
  // serial number content: arbitrary value
  parameter logic [127:0] SERIAL = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic d_in,
  output logic q_out,
  output logic q_oe_out,
  input wire logic protect_field_high_in,
  input wire logic protect_field_low_in,
  output logic busy_flag_out,
  output logic write_latch_flag_out,
  output logic id_lock_out
);
  localparam int AW = $clog2(MEM_BYTES);
  localparam int NG = MEM_BYTES / 4;
  localparam int TW = $clog2(T_WRITE + 1);
  localparam logic [TW-1:0] T_ERASE_END = TW'(T_WRITE / 2 - 1);
  localparam logic [TW-1:0] T_PROG_END = TW'(T_WRITE - 1);
  localparam logic [5:0] FF_CHK = sne_pkg::ecc_check({4{`SNE_FILL_BYTE}});

  generate
    if (MEM_BYTES < 64 || (MEM_BYTES & (MEM_BYTES - 1)) != 0 || MEM_BYTES > 65536 || T_WRITE < 4)
    begin : g_bad
      $error("sne_engine: unsupported MEM_BYTES or T_WRITE");
    end
  endgenerate

  // ---------------------------------------------------------------
  // storage and write-cycle state (system clock)
  // ---------------------------------------------------------------
  logic [31:0] mem_reg [NG];
  logic [5:0] chk_reg [NG];
  logic [7:0] idp_reg [32];
  logic lock_reg;
  logic latch_reg;
  sne_pkg::sne_state_t st_reg;
  sne_pkg::sne_kind_t kind_reg;
  logic [TW-1:0] tmr_reg;
  logic [AW-6:0] page_reg;
  logic [31:0] stage_reg [8];
  logic [31:0] bmask_reg;
  logic cs_d_reg;
  logic seen_reg;

  // ---------------------------------------------------------------
  // link side (serial clock)
  // ---------------------------------------------------------------
  sne_pkg::sne_frame_t frm_reg;
  logic sel_reg;
  logic tgl_reg;
  logic [6:0] sh_reg;
  logic [AW-1:0] rptr_reg;
  logic [4:0] wptr_reg;
  logic [7:0] pbuf_reg [32];
  logic [31:0] mask_reg;
  logic rd_go_reg;
  logic q_reg;
  logic oe_reg;
  logic busy_s;

  wire busy = st_reg != sne_pkg::ST_IDLE;
  wire [1:0] bp = {protect_field_high_in, protect_field_low_in};
  wire [7:0] shv = {sh_reg, d_in};
  wire done_byte = sel_reg && frm_reg.bitc == 3'h7;
  wire in_data = frm_reg.byt >= 3'h3;
  wire op_wr_id = frm_reg.op == `SNE_WRITE_IDENT_PAGE_CMD;
  wire a_lock = frm_reg.addr[`SNE_A_LOCK_BIT];
  wire is_rd_arr = frm_reg.op == `SNE_READ_ARRAY_CMD;
  wire is_rd_id = frm_reg.op == `SNE_READ_IDENT_PAGE_CMD && !a_lock;
  wire is_rd_lk = frm_reg.op == `SNE_READ_IDENT_PAGE_CMD && a_lock;
  wire is_rd_sn = frm_reg.op == `SNE_READ_SERIAL_NUMBER_CMD
    && frm_reg.addr[`SNE_A_SERIAL_BIT];
  wire rd_kind = is_rd_arr || is_rd_id || is_rd_lk || is_rd_sn;
  wire is_wr = frm_reg.op == `SNE_WRITE_ARRAY_CMD || (op_wr_id && !a_lock);
  wire wr_take = done_byte && in_data && is_wr;

  // busy only rises with the link idle; two sck edges of the opcode refresh it
  sne_sync #(.W(1), .RST(1'b0)) u_busy_sync (
    .clk_in(sck_in), .rst_in(1'b0), .d_in(busy), .q_out(busy_s));

  // cleared asynchronously while deselected, so the first edge of a frame sees zero
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) sel_reg <= 1'b0;
    else sel_reg <= 1'b1;
  end

  // frame registers are not cleared by deselect: the system side reads them after it
  always_ff @(posedge sck_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frm_reg <= '0;
      tgl_reg <= 1'b0;
      sh_reg <= 7'h0;
      rptr_reg <= '0;
      wptr_reg <= 5'h0;
      mask_reg <= 32'h0;
      rd_go_reg <= 1'b0;
    end else begin
      sh_reg <= shv[6:0];
      frm_reg.bitc <= sel_reg ? frm_reg.bitc + 3'h1 : 3'h1;
      if (!sel_reg) begin
        tgl_reg <= !tgl_reg;
        frm_reg.byt <= 3'h0;
        rd_go_reg <= 1'b0;
      end else if (done_byte) begin
        if (frm_reg.byt != 3'h5) frm_reg.byt <= frm_reg.byt + 3'h1;
        case (frm_reg.byt)
          3'h0: frm_reg.op <= shv;
          3'h1: frm_reg.addr[15:8] <= shv;
          3'h2: begin
            frm_reg.addr[7:0] <= shv;
            rptr_reg <= AW'({frm_reg.addr[15:8], shv});
            wptr_reg <= shv[4:0];
            mask_reg <= 32'h0;
            rd_go_reg <= rd_kind && !busy_s;
          end
          default: begin
            // a write steps only the in-page part of the address counter
            if (is_wr) begin
              rptr_reg <= {rptr_reg[AW-1:5], rptr_reg[4:0] + 5'h1};
              wptr_reg <= wptr_reg + 5'h1;
              mask_reg[wptr_reg] <= 1'b1;
            end else begin
              rptr_reg <= rptr_reg + AW'(1);
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sck_in) begin
    if (wr_take) pbuf_reg[wptr_reg] <= shv;
  end

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  // storage changes only inside a write cycle and reads are refused then,
  // so the link may read it directly without a word crossing
  logic [31:0] rd_fix;
  wire [AW-3:0] rd_idx = rptr_reg[AW-1:2];
  sne_ecc u_rd_ecc (
    .data_in(mem_reg[rd_idx]), .chk_in(chk_reg[rd_idx]), .fix_out(rd_fix));
  wire [7:0] arr_byte = rd_fix[{rptr_reg[1:0], 3'h0} +: 8];
  wire [7:0] sn_byte = SERIAL[{rptr_reg[3:0], 3'h0} +: 8];
  // ident reads past offset 31 wrap; that data is undefined for the host
  wire [7:0] cur_byte = is_rd_arr ? arr_byte
    : is_rd_id ? idp_reg[rptr_reg[4:0]]
    : is_rd_lk ? {7'h0, lock_reg}
    : sn_byte;

  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      q_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= sel_reg && rd_go_reg;
      q_reg <= cur_byte[3'h7 - frm_reg.bitc];
    end
  end
  assign q_out = q_reg;
  assign q_oe_out = oe_reg;

  // ---------------------------------------------------------------
  // frame end decode (system clock)
  // ---------------------------------------------------------------
  logic cs_s;
  logic tgl_s;
  sne_sync #(.W(2), .RST(2'b01)) u_frame_sync (
    .clk_in(clk_in), .rst_in(sys_rst_in), .d_in({tgl_reg, cs_n_in}), .q_out({tgl_s, cs_s}));
  // a toggle that has not moved means select pulsed without clocks: nothing to do
  wire cs_rise = cs_s && !cs_d_reg;
  wire commit = cs_rise && (tgl_s != seen_reg) && !busy;
  wire bound = frm_reg.bitc == 3'h0;
  wire one_data = frm_reg.byt == 3'h4;
  wire any_data = frm_reg.byt >= 3'h4;
  wire prot = bp == `SNE_BP_ALL || (bp == `SNE_BP_HALF && frm_reg.addr[AW-1])
    || (bp == `SNE_BP_QUARTER && frm_reg.addr[AW-1:AW-2] == 2'h3);
  wire f_write_enable_cmd = frm_reg.op == `SNE_WRITE_ENABLE_CMD && frm_reg.byt == 3'h1 && bound;
  wire go_arr = frm_reg.op == `SNE_WRITE_ARRAY_CMD && latch_reg && bound
    && any_data && !prot;
  wire go_id = op_wr_id && !a_lock && latch_reg && bound && any_data && !lock_reg;
  wire go_lk = op_wr_id && a_lock && latch_reg && bound && one_data
    && bp != `SNE_BP_ALL;
  wire erase_end = st_reg == sne_pkg::ST_ERASE && tmr_reg == T_ERASE_END;
  wire prog_end = st_reg == sne_pkg::ST_PROG && tmr_reg == T_PROG_END;

  // old contents of the addressed page, corrected, merged with new bytes
  logic [31:0] merged [8];
  generate
    for (genvar g = 0; g < 8; g++) begin : g_grp
      logic [31:0] old_w;
      wire [AW-3:0] gi = {frm_reg.addr[AW-1:5], 3'(g)};
      sne_ecc u_old_ecc (
        .data_in(mem_reg[gi]), .chk_in(chk_reg[gi]), .fix_out(old_w));
      for (genvar b = 0; b < 4; b++) begin : g_byte
        assign merged[g][8*b +: 8] = mask_reg[4*g+b] ? pbuf_reg[4*g+b]
          : old_w[8*b +: 8];
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg <= sne_pkg::ST_IDLE;
      kind_reg <= sne_pkg::K_ARRAY;
      tmr_reg <= '0;
      latch_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      seen_reg <= 1'b0;
      page_reg <= '0;
      bmask_reg <= 32'h0;
    end else begin
      cs_d_reg <= cs_s;
      if (cs_rise) seen_reg <= tgl_s;
      case (st_reg)
        sne_pkg::ST_IDLE: begin
          tmr_reg <= '0;
          if (commit && f_write_enable_cmd) begin
            latch_reg <= 1'b1;
          end else if (commit && (go_arr || go_id || go_lk)) begin
            st_reg <= sne_pkg::ST_ERASE;
            kind_reg <= go_arr ? sne_pkg::K_ARRAY
              : go_id ? sne_pkg::K_IDPG : sne_pkg::K_LOCK;
            page_reg <= frm_reg.addr[AW-1:5];
            bmask_reg <= mask_reg;
            for (int g = 0; g < 8; g++) begin
              stage_reg[g] <= merged[g];
            end
          end
        end
        sne_pkg::ST_ERASE: begin
          tmr_reg <= tmr_reg + TW'(1);
          if (erase_end) st_reg <= sne_pkg::ST_PROG;
        end
        default: begin
          tmr_reg <= tmr_reg + TW'(1);
          if (prog_end) begin
            st_reg <= sne_pkg::ST_IDLE;
            latch_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // reset stands for the delivered state of the nonvolatile contents
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NG; i++) begin
        mem_reg[i] <= {4{`SNE_FILL_BYTE}};
        chk_reg[i] <= FF_CHK;
      end
      for (int i = 0; i < 32; i++) begin
        idp_reg[i] <= `SNE_FILL_BYTE;
      end
      lock_reg <= 1'b0;
    end else begin
      for (int g = 0; g < 8; g++) begin
        if (kind_reg == sne_pkg::K_ARRAY && bmask_reg[4*g +: 4] != 4'h0) begin
          if (erase_end) begin
            mem_reg[{page_reg, g[2:0]}] <= {4{`SNE_FILL_BYTE}};
            chk_reg[{page_reg, g[2:0]}] <= FF_CHK;
          end
          if (prog_end) begin
            mem_reg[{page_reg, g[2:0]}] <= stage_reg[g];
            chk_reg[{page_reg, g[2:0]}] <= sne_pkg::ecc_check(stage_reg[g]);
          end
        end
      end
      for (int b = 0; b < 32; b++) begin
        if (kind_reg == sne_pkg::K_IDPG && bmask_reg[b]) begin
          if (erase_end) idp_reg[b] <= `SNE_FILL_BYTE;
          if (prog_end) idp_reg[b] <= stage_reg[b/4][8*(b%4) +: 8];
        end
      end
      if (prog_end && kind_reg == sne_pkg::K_LOCK) lock_reg <= 1'b1;
    end
  end

  assign busy_flag_out = busy;
  assign write_latch_flag_out = latch_reg;
  assign id_lock_out = lock_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_read_busy_refused: assert property (@(posedge sck_in) disable iff (cs_n_in)
    (done_byte && frm_reg.byt == 3'h2 && busy_s) |=> !rd_go_reg ##1 !oe_reg)
    else $error("read started while busy");
  a_busy_from_erase: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(busy) |-> $past(commit) && st_reg == sne_pkg::ST_ERASE && tmr_reg == '0)
    else $error("write cycle began without a frame end");
  a_erase_then_prog: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(st_reg == sne_pkg::ST_PROG) |-> $past(tmr_reg) == T_ERASE_END)
    else $error("program step not preceded by a full erase step");
  a_busy_clears_late: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(busy) |-> $past(st_reg) == sne_pkg::ST_PROG && $past(tmr_reg) == T_PROG_END)
    else $error("busy cleared before the write time");
  a_page_wrap: assert property (@(posedge sck_in) disable iff (sys_rst_in)
    wr_take |=> wptr_reg == $past(wptr_reg) + 5'h1 && rptr_reg[AW-1:5] == $past(rptr_reg[AW-1:5])
      || $past(frm_reg.byt) < 3'h3)
    else $error("write pointer left the page");
  a_write_reject: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cs_rise && frm_reg.op == `SNE_WRITE_ARRAY_CMD && (!latch_reg || busy || !bound || prot))
      |=> ##1 st_reg != sne_pkg::ST_ERASE || $past(st_reg, 2) != sne_pkg::ST_IDLE)
    else $error("rejected write started a cycle");
  a_group_rewrite: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (prog_end && kind_reg == sne_pkg::K_ARRAY && bmask_reg[3:0] != 4'h0)
      |=> mem_reg[{page_reg, 3'h0}] == $past(stage_reg[0]))
    else $error("group not programmed with merged contents");
  a_lock_refused: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (commit && op_wr_id && a_lock && (bp == `SNE_BP_ALL || !latch_reg || !one_data))
      |=> st_reg == sne_pkg::ST_IDLE)
    else $error("lock accepted against its conditions");
  a_latch_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    prog_end |=> !latch_reg && !busy)
    else $error("latch survived a completed write");
  a_id_locked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (commit && lock_reg && op_wr_id && !a_lock) |=> st_reg == sne_pkg::ST_IDLE)
    else $error("write to locked ident page accepted");
  c_page_write: cover property (@(posedge clk_in) commit && go_arr && !one_data);
  c_lock_done: cover property (@(posedge clk_in) prog_end && kind_reg == sne_pkg::K_LOCK);
  c_array_read: cover property (@(negedge sck_in) oe_reg && is_rd_arr);
endmodule
`default_nettype wire

// ==== verilog/sne_map.svh ====
/*
  Constants of the serial EEPROM instruction engine: opcodes, address
  field positions, sizes and timing. Assumes inclusion by bare name.
*/
`ifndef SNE_MAP_SVH
`define SNE_MAP_SVH
`define SNE_WRITE_ENABLE_CMD 8'h06
`define SNE_READ_ARRAY_CMD 8'h03
`define SNE_WRITE_ARRAY_CMD 8'h02
`define SNE_READ_IDENT_PAGE_CMD 8'h83
`define SNE_WRITE_IDENT_PAGE_CMD 8'h82
`define SNE_READ_SERIAL_NUMBER_CMD 8'h4b
`define SNE_A_LOCK_BIT 10
`define SNE_A_SERIAL_BIT 9
`define SNE_PAGE_BYTES 32
`define SNE_MEM_BYTES 4096
`define SNE_FILL_BYTE 8'hff
`define SNE_BP_ALL 2'h3
`define SNE_BP_HALF 2'h2
`define SNE_BP_QUARTER 2'h1
`define SNE_CLK_NS 40
`define SNE_SELF_TIMED_WRITE_TIME_NS 5000000
`endif

// ==== verilog/sne_pkg.sv ====
/*
  Types and error-correction code helpers of the EEPROM engine.
  Assumes nothing of its surroundings.
*/
package sne_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} sne_state_t;
  typedef enum logic [1:0] {K_ARRAY, K_IDPG, K_LOCK} sne_kind_t;
  typedef struct packed {
    logic [7:0] op;
    logic [15:0] addr;
    logic [2:0] bitc;
    logic [2:0] byt;
  } sne_frame_t;

  // check code of data bit idx: the idx-th number from 3 up that is no power of two
  function automatic logic [5:0] ecc_code(input int idx);
    int k;
    logic [5:0] c;
    k = 0;
    c = 6'h0;
    for (int n = 3; n < 64; n++) begin
      if ((n & (n - 1)) != 0) begin
        if (k == idx) c = 6'(n);
        k = k + 1;
      end
    end
    return c;
  endfunction

  function automatic logic [5:0] ecc_check(input logic [31:0] d);
    logic [5:0] c;
    c = 6'h0;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) c = c ^ ecc_code(i);
    end
    return c;
  endfunction
endpackage

// ==== verilog/sne_sync.sv ====
/*
  Two-flop level synchroniser, one stage pair per bit.
  Assumes d_in comes from another clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sne_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic hold_reg;
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          meta_reg <= RST[i];
          hold_reg <= RST[i];
        end else begin
          meta_reg <= d_in[i];
          hold_reg <= meta_reg;
        end
      end
      assign q_out[i] = hold_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verilog/sne_ecc.sv ====
/*
  Single-bit correction of one aligned four-byte group.
  Assumes chk_in was made by sne_pkg::ecc_check when the group was written.
*/
`timescale 1ns/100ps
`default_nettype none
module sne_ecc (
  input wire logic [31:0] data_in,
  input wire logic [5:0] chk_in,
  output logic [31:0] fix_out
);
  wire [5:0] syn = sne_pkg::ecc_check(data_in) ^ chk_in;
  // a flipped check bit gives a power-of-two syndrome and touches no data bit
  generate
    for (genvar i = 0; i < 32; i++) begin : g_fix
      assign fix_out[i] = data_in[i] ^ (syn == sne_pkg::ecc_code(i));
    end
  endgenerate
endmodule
`default_nettype wire

// ==== testbench/sne_host.sv ====
/*
  Serial host model that drives select, link clock and data into the
  EEPROM engine and collects the bytes read back.
  Assumes the bench calls frame(), fills wbuf and reads rbuf/oe_ok/oe_any.
*/
`timescale 1ns/100ps
`default_nettype none
module sne_host (
  output logic sck_out,
  output logic cs_n_out,
  output logic d_out,
  input wire logic q_in,
  input wire logic q_oe_in
);
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  logic oe_ok;
  logic oe_any;
  logic e_last;

  // link clock rests low between frames (mode 0)
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    d_out = 1'b0;
  end

  task automatic bitx(input logic b, output logic s);
    d_out = b;
    #24;
    sck_out = 1'b1;
    s = q_in;
    e_last = q_oe_in;
    oe_any = oe_any | q_oe_in;
    #24;
    sck_out = 1'b0;
  endtask

  task automatic frame(input logic [7:0] op, input logic [15:0] addr, input int nw,
                       input int nr, input int extra);
    logic s;
    wait ($time >= 100000);
    oe_ok = 1'b1;
    oe_any = 1'b0;
    cs_n_out = 1'b0;
    #24;
    for (int i = 7; i >= 0; i--) bitx(op[i], s);
    if (op != 8'h06) for (int i = 15; i >= 0; i--) bitx(addr[i], s);
    for (int k = 0; k < nw; k++) for (int i = 7; i >= 0; i--) bitx(wbuf[k][i], s);
    for (int i = 0; i < extra; i++) bitx(1'b1, s);
    for (int k = 0; k < nr; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bitx(1'b0, s);
        rbuf[k][i] = s;
        oe_ok = oe_ok & e_last;
      end
    end
    // select rises between the last sampling edge and the next one
    #12;
    cs_n_out = 1'b1;
    d_out = ~d_out;
    #200;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
/*
  Self-checking bench of the EEPROM instruction engine.
  Assumes sne_engine and the host model sne_host.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int TW = 60;
  // serial number content: arbitrary value
  localparam logic [127:0] SER = 128'h00112233445566778899aabbccddeeff;
  logic clk_in, sys_rst_in, sck, cs_n, d, q, q_oe, bp_hi, bp_lo, busy, write_latch_flag, lock;
  int error_cnt = 0;
  int checked = 0;
  int run = 0;
  int last_len = 0;

  sne_engine #(.MEM_BYTES(4096), .T_WRITE(TW), .SERIAL(SER)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck), .cs_n_in(cs_n), .d_in(d),
    .q_out(q), .q_oe_out(q_oe), .protect_field_high_in(bp_hi),
    .protect_field_low_in(bp_lo), .busy_flag_out(busy),
    .write_latch_flag_out(write_latch_flag), .id_lock_out(lock)
  );
  sne_host u_host (.sck_out(sck), .cs_n_out(cs_n), .d_out(d), .q_in(q), .q_oe_in(q_oe));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // length of the last busy period in clock cycles
  always @(posedge clk_in) begin
    if (busy === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (busy !== lvl) begin
      check(16'(busy), 16'(lvl));
      close_out;
    end
  endtask

  task automatic write_enable_cmd;
    u_host.frame(8'h06, 16'h0, 0, 0, 0);
    repeat (8) @(negedge clk_in);
  endtask

  // a frame that writes; ok says whether a timed cycle must follow,
  // and rop is a read tried while that cycle runs
  task automatic commit(input logic [7:0] op, input logic [15:0] addr, input int nw,
                        input int extra, input bit ok, input logic [7:0] rop);
    u_host.frame(op, addr, nw, 0, extra);
    if (ok) begin
      wait_busy(1'b1);
      u_host.frame(rop, 16'h0200, 0, 1, 0);
      check(16'(u_host.oe_any), 16'h0);
      wait_busy(1'b0);
      @(negedge clk_in);
      check(16'(last_len), 16'(TW));
      check(16'(write_latch_flag), 16'h0);
    end else begin
      repeat (10) @(negedge clk_in);
      check(16'(busy), 16'h0);
    end
  endtask

  task automatic rd(input logic [7:0] op, input logic [15:0] addr, input int n,
                    input logic [31:0] exp);
    u_host.frame(op, addr, 0, n, 0);
    check(16'(u_host.oe_ok), 16'h1);
    for (int i = 0; i < n; i++) check(16'(u_host.rbuf[i]), 16'(exp[8*(n-1-i)+:8]));
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    // start low so the asynchronous clear of the link registers sees a real edge
    sys_rst_in = 1'b0;
    bp_hi = 1'b0;
    bp_lo = 1'b0;
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    check(16'({write_latch_flag, busy, lock}), 16'h0);
    rd(8'h03, 16'h0ffe, 4, 32'hffffffff);
    rd(8'h83, 16'h0400, 2, 32'h0000);
    $display("test reset done");
    u_host.wbuf[0] = 8'h5a;
    u_host.wbuf[1] = 8'ha5;
    u_host.wbuf[2] = 8'h3c;
    commit(8'h02, 16'h003e, 1, 0, 0, 8'h03);
    write_enable_cmd();
    check(16'(write_latch_flag), 16'h1);
    commit(8'h02, 16'h003e, 3, 0, 1, 8'h03);
    rd(8'h03, 16'h003e, 3, 32'h5aa5ff);
    rd(8'h03, 16'h001f, 3, 32'hff3cff);
    $display("test array write done");
    write_enable_cmd();
    commit(8'h02, 16'h0100, 1, 3, 0, 8'h03);
    @(negedge clk_in);
    bp_hi = 1'b1;
    bp_lo = 1'b1;
    commit(8'h02, 16'h0fe0, 1, 0, 0, 8'h03);
    commit(8'h82, 16'h0400, 1, 0, 0, 8'h03);
    @(negedge clk_in);
    bp_lo = 1'b0;
    commit(8'h02, 16'h0800, 1, 0, 0, 8'h03);
    @(negedge clk_in);
    bp_hi = 1'b0;
    bp_lo = 1'b1;
    commit(8'h02, 16'h0c00, 1, 0, 0, 8'h03);
    @(negedge clk_in);
    bp_hi = 1'b0;
    bp_lo = 1'b0;
    check(16'({write_latch_flag, lock}), 16'h2);
    $display("test refusals done");
    commit(8'h82, 16'hf805, 2, 0, 1, 8'h83);
    rd(8'h83, 16'hf805, 3, 32'h5aa5ff);
    commit(8'h82, 16'h0400, 1, 0, 0, 8'h03);
    write_enable_cmd();
    commit(8'h82, 16'h0400, 1, 0, 1, 8'h4b);
    check(16'(lock), 16'h1);
    rd(8'h83, 16'h0400, 2, 32'h0101);
    write_enable_cmd();
    commit(8'h82, 16'h0005, 1, 0, 0, 8'h03);
    $display("test ident page done");
    rd(8'h4b, 16'h020e, 3, {8'h0, SER[119:112], SER[127:120], SER[7:0]});
    u_host.frame(8'h4b, 16'h000e, 0, 1, 0);
    check(16'(u_host.oe_any), 16'h0);
    $display("test serial done");
    close_out();
  end
endmodule
`default_nettype wire
